// File: logic/ass_defs.vh
// constants for the conversion scan sequencer
`ifndef ASS_DEFS_VH
`define ASS_DEFS_VH
`define ASS_RES_W       10
`define ASS_CH_MAX      8
`define ASS_MODE_SCAN   2'h0
`define ASS_MODE_DUAL   2'h1
`define ASS_MODE_STEP   2'h2
`define ASS_SRC_TIMER   2'h0
`define ASS_SRC_NOW     2'h1
`define ASS_SRC_EDGE    2'h2
`define ASS_SCAN_SPLIT  4'h4
`define ASS_DUAL_GRP_S  4'h4
`define ASS_DUAL_GRP_L  4'h8
`endif

// File: logic/ass_edge_sync.v
// synchroniser and both-edge detector for the external start pin
module ass_edge_sync (
  input  wire core_clk,
  input  wire reset,
  input  wire pin_in,
  output reg  edge_pulse
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_q     <= 1'b0;
      sync_q     <= 1'b0;
      last_q     <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      meta_q     <= pin_in;
      sync_q     <= meta_q;
      last_q     <= sync_q;
      edge_pulse <= sync_q ^ last_q;
    end
  end
endmodule // ass_edge_sync

// File: logic/ass_sequencer.v
// conversion sequencer for a multiplexed 10-bit converter
// Operation
// - results are 10 bits and the channel count is 8 or 4 by parameter.
// - auto-scan converts each enabled channel and writes its result into that channel's slot.
// - auto-scan raises its event after the first four conversions or after all, and a second one at the end.
// - after the last enabled channel the scan restarts at the first and runs until stopped.
// - dual mode alternates two channels into slots 0 and 2 for the first and 1 and 3 for the second.
// - dual mode raises its event after every group of four or eight conversions.
// - single-step converts one channel per start, raises its event, then waits for the next start.
// - a timer overflow starts a conversion and further overflows are ignored while it runs.
// - choosing the immediate source starts a conversion at once.
// - an edge on the start pin starts a conversion and further edges are ignored while it runs.
`include "ass_defs.vh"
module ass_sequencer #(
  parameter CH_NUM = 8
) (
  // clock and reset
  input  wire                 core_clk,
  input  wire                 reset,
  // configuration
  input  wire                 run_en,
  input  wire [1:0]           mode_sel,
  input  wire [1:0]           start_src,
  input  wire [7:0]           chan_enable,
  input  wire [2:0]           dual_first,
  input  wire [2:0]           dual_second,
  input  wire                 scan_split_four,
  input  wire                 dual_group_eight,
  // start sources
  input  wire                 timer0_overflow,
  input  wire                 edge_start_pin,
  // converter core
  output reg                  conv_start,
  output reg  [2:0]           conv_channel,
  input  wire                 conv_done,
  input  wire [9:0]           conv_result,
  // results and status
  output reg                  result_write,
  output reg  [2:0]           result_slot,
  output reg  [9:0]           result_data,
  output reg                  conv_event,
  output reg                  busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_STOP = 2'h3;

  reg  [1:0] state_q;
  reg  [2:0] chan_q;
  reg  [3:0] count_q;
  reg        run_last_q;
  reg        dual_sel_q;
  reg  [1:0] dual_slot_q;
  wire       pin_edge;
  wire [7:0] chan_mask;
  wire       trigger;
  wire [2:0] first_ch;
  wire [2:0] next_ch;
  wire       is_last;

  ass_edge_sync u_sync (
    .core_clk   (core_clk),
    .reset      (reset),
    .pin_in     (edge_start_pin),
    .edge_pulse (pin_edge)
  );

  // channels beyond the variant's count never convert
  assign chan_mask = chan_enable & ((CH_NUM >= 8) ? 8'hff : 8'h0f);

  // lowest enabled channel above cur, or lowest overall with from_start; top bit flags a find
  function [3:0] next_en;
    input [7:0] mask;
    input [2:0] cur;
    input       from_start;
    integer     i;
    reg         found;
    reg  [2:0]  pick;
    begin
      found = 1'b0;
      pick  = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (mask[i] && (from_start || i > cur)) begin
          found = 1'b1;
          pick  = i[2:0];
        end
      end
      next_en = {found, pick};
    end
  endfunction

  // mode decode shared by the arming, start and result paths
  function is_dual;
    input [1:0] m;
    begin
      is_dual = (m == `ASS_MODE_DUAL);
    end
  endfunction

  // dual channels fold into the variant's range so a missing input is never selected
  function [2:0] dual_pick;
    input       sel;
    input [2:0] ch_a;
    input [2:0] ch_b;
    reg   [2:0] ch;
    begin
      ch        = sel ? ch_b : ch_a;
      dual_pick = (CH_NUM >= 8) ? ch : {1'b0, ch[1:0]};
    end
  endfunction

  wire [3:0] nx_up  = next_en(chan_mask, chan_q, 1'b0);
  wire [3:0] nx_low = next_en(chan_mask, 3'h0, 1'b1);
  assign first_ch = nx_low[2:0];
  assign is_last  = ~nx_up[3];
  assign next_ch  = is_last ? first_ch : nx_up[2:0];

  // timer and edge triggers are only looked at in ST_WAIT, so extra ones are ignored
  assign trigger = (start_src == `ASS_SRC_TIMER) ? timer0_overflow :
                   (start_src == `ASS_SRC_EDGE)  ? pin_edge :
                   (start_src == `ASS_SRC_NOW);

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q      <= ST_IDLE;
      chan_q       <= 3'h0;
      count_q      <= 4'h0;
      run_last_q   <= 1'b0;
      dual_sel_q   <= 1'b0;
      dual_slot_q  <= 2'h0;
      conv_start   <= 1'b0;
      conv_channel <= 3'h0;
      result_write <= 1'b0;
      result_slot  <= 3'h0;
      result_data  <= 10'h000;
      conv_event   <= 1'b0;
      busy         <= 1'b0;
    end else begin
      run_last_q   <= run_en;
      conv_start   <= 1'b0;
      result_write <= 1'b0;
      conv_event   <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          busy <= 1'b0;
          // arming only on a fresh rising run_en, so a stop holds until run_en rises again
          if (run_en && !run_last_q && (chan_mask != 8'h00 || is_dual(mode_sel))) begin
            chan_q      <= first_ch;
            count_q     <= 4'h0;
            dual_sel_q  <= 1'b0;
            dual_slot_q <= 2'h0;
            state_q     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!run_en) begin
            state_q <= ST_STOP;
          end else if (trigger) begin
            conv_start   <= 1'b1;
            conv_channel <= is_dual(mode_sel) ? dual_pick(dual_sel_q, dual_first, dual_second) : chan_q;
            busy         <= 1'b1;
            state_q      <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (!run_en) begin
            state_q <= ST_STOP; // abandon the running conversion
          end else if (conv_done) begin
            result_write <= 1'b1;
            result_data  <= conv_result;
            busy         <= 1'b0;
            count_q      <= count_q + 4'h1;
            if (is_dual(mode_sel)) begin
              result_slot <= {1'b0, dual_slot_q};
              dual_slot_q <= dual_slot_q + 2'h1;
              dual_sel_q  <= ~dual_sel_q;
              if (count_q + 4'h1 == (dual_group_eight ? `ASS_DUAL_GRP_L : `ASS_DUAL_GRP_S)) begin
                conv_event <= 1'b1;
                count_q    <= 4'h0;
              end
              state_q <= (start_src == `ASS_SRC_NOW) ? ST_CONV : ST_WAIT;
              if (start_src == `ASS_SRC_NOW) begin
                conv_start   <= 1'b1;
                conv_channel <= dual_pick(~dual_sel_q, dual_first, dual_second);
                busy         <= 1'b1;
              end
            end else begin
              result_slot <= chan_q;
              chan_q      <= next_ch;
              if (mode_sel == `ASS_MODE_STEP) begin
                conv_event <= 1'b1;
                state_q    <= ST_WAIT;
              end else begin
                if (is_last) begin
                  conv_event <= 1'b1;
                  count_q    <= 4'h0;
                end else if (scan_split_four && count_q + 4'h1 == `ASS_SCAN_SPLIT) begin
                  conv_event <= 1'b1;
                end
                // free running: chain straight on with immediate start, else wait for a trigger
                if (start_src == `ASS_SRC_NOW) begin
                  conv_start   <= 1'b1;
                  conv_channel <= next_ch;
                  busy         <= 1'b1;
                  state_q      <= ST_CONV;
                end else begin
                  state_q <= ST_WAIT;
                end
              end
            end
          end
        end
        ST_STOP: begin
          busy    <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // ass_sequencer

// File: tb/ass_chk.sv
// port assertions for the conversion sequencer
`include "ass_defs.vh"
module ass_chk #(
  parameter CH_NUM = 8
) (
  // ports group together by width to keep the checker short
  input wire logic       core_clk, reset, run_en, scan_split_four, dual_group_eight,
  input wire logic       timer0_overflow, edge_start_pin, conv_start, conv_done,
  input wire logic       result_write, conv_event, busy,
  input wire logic [1:0] mode_sel, start_src,
  input wire logic [7:0] chan_enable,
  input wire logic [2:0] dual_first, dual_second, conv_channel, result_slot,
  input wire logic [9:0] conv_result, result_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  chk_busy_start: assert property (conv_start |-> busy)
    else $error("busy low at start");
  chk_retrigger_ign: assert property (conv_start ##1 !conv_done |-> !conv_start)
    else $error("start while converting");
  chk_write_data: assert property (busy && conv_done && run_en |=> result_write && result_data == $past(conv_result))
    else $error("result not written");
  chk_scan_slot: assert property (mode_sel != `ASS_MODE_DUAL && result_write |-> chan_enable[result_slot])
    else $error("slot of disabled channel");
  chk_dual_slot: assert property (mode_sel == `ASS_MODE_DUAL && result_write |->
    !result_slot[2] && (!conv_event || result_slot[1:0] == 2'h3))
    else $error("dual slot out of range or group end off slot three");
  chk_step_event: assert property (mode_sel == `ASS_MODE_STEP && result_write |-> conv_event)
    else $error("no event in single step");
  chk_event_write: assert property (conv_event |-> result_write)
    else $error("event without result");
  chk_stop_idle: assert property ($fell(run_en) |-> ##2 !busy && !conv_start)
    else $error("still busy after stop");
endmodule // ass_chk
bind ass_sequencer ass_chk #(.CH_NUM(CH_NUM)) u_chk (.*);

// File: tb/ass_core_model.sv
// behavioural converter core with a chosen latency
module ass_core_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // converter handshake
  input  wire logic       conv_start,
  input  wire logic [2:0] conv_channel,
  input  wire logic [3:0] lat,
  output logic            conv_done,
  output logic [9:0]      conv_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [2:0] ch_q;
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      ch_q <= 3'h0;
      conv_done <= 1'b0;
      conv_result <= 10'h0;
    end else begin
      conv_done <= 1'b0;
      // stale data flips each cycle so it never passes as a result
      conv_result <= ~conv_result;
      if (conv_start) begin
        cnt_q <= lat;
        ch_q <= conv_channel;
      end else if (cnt_q == 4'h1) begin
        conv_done <= 1'b1;
        conv_result <= {ch_q, ch_q, ch_q, 1'b1};
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // ass_core_model

// File: tb/tb.sv
// self-checking bench for the conversion sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, run_en = 0, split = 0, grp8 = 0, tmr = 0, pin = 0;
  logic [1:0] mode = 2'h0, src = 2'h0;
  logic [7:0] mask = 8'h0;
  logic [2:0] df = 3'h0, ds = 3'h0, slot, conv_channel;
  logic [9:0] data, conv_result;
  logic [3:0] lat = 4'h4;
  logic conv_start, conv_done, wr, ev, busy;
  logic [31:0] rs = 32'h50;
  int n_errors = 0, num_checks = 0, n_w, k, prev, c, w0;
  always #4 core_clk = ~core_clk;
  ass_sequencer #(.CH_NUM(8)) DUT (.core_clk, .reset, .run_en, .mode_sel(mode), .start_src(src),
    .chan_enable(mask), .dual_first(df), .dual_second(ds), .scan_split_four(split),
    .dual_group_eight(grp8), .timer0_overflow(tmr), .edge_start_pin(pin), .conv_start, .conv_channel,
    .conv_done, .conv_result, .result_write(wr), .result_slot(slot), .result_data(data),
    .conv_event(ev), .busy);
  ass_core_model u_core (.core_clk, .reset, .conv_start, .conv_channel, .lat, .conv_done, .conv_result);
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic int nxt(int p, logic [7:0] m);
    for (int i = 1; i <= 8; i++) if (m[(p + i) % 8]) return (p + i) % 8;
    return 0;
  endfunction
  function automatic logic [9:0] res(logic [2:0] ch);
    return {ch, ch, ch, 1'b1};
  endfunction
  task automatic cmp(string what, logic [9:0] e, logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // outputs are read mid-cycle, clear of the edge that launches them
  always @(negedge core_clk) if (wr === 1'b1) begin
    if (mode == 2'h1) begin
      cmp("dual slot", 10'(n_w % 4), 10'(slot));
      cmp("dual data", res(n_w[0] ? ds : df), data);
      cmp("dual event", 10'((n_w + 1) % (grp8 ? 8 : 4) == 0), 10'(ev));
    end else begin
      c = nxt(prev, mask);
      k = c > prev ? k + 1 : 1;
      prev = c;
      cmp("scan slot", 10'(c), 10'(slot));
      cmp("scan data", res(3'(c)), data);
      cmp("scan event", 10'(mode == 2'h2 || nxt(c, mask) <= c || (split && k == 4)), 10'(ev));
    end
    n_w++;
  end
  task automatic pulse(logic [1:0] s);
    if (s == 2'h0) begin
      tmr = 1;
      @(negedge core_clk);
      tmr = 0;
    end else if (s == 2'h2) pin = ~pin;
  endtask
  task automatic run(logic [1:0] m, logic [1:0] s);
    @(negedge core_clk);
    mode = m;
    src = s;
    lat = 4'h4 + 4'(rnd() % 8);
    mask = 8'(rnd());
    if (mask == 8'h0) mask = 8'h81;
    {split, grp8, df, ds} = 8'(rnd());
    n_w = 0;
    prev = 7;
    k = 0;
    run_en = 1;
    repeat (3) begin
      repeat (4) @(negedge core_clk);
      pulse(s);
      // second trigger falls inside the conversion and must be dropped
      repeat (3) @(negedge core_clk);
      pulse(s);
      repeat (16) @(negedge core_clk);
    end
    if (m == 2'h2 && s != 2'h1) cmp("step count", 10'h3, 10'(n_w));
    else cmp("started", 10'h1, 10'(n_w > 0));
    run_en = 0;
    repeat (3) @(negedge core_clk);
    cmp("busy after stop", 10'h0, 10'(busy));
    w0 = n_w;
    pulse(s);
    repeat (20) @(negedge core_clk);
    cmp("writes after stop", 10'(w0), 10'(n_w));
    $display("test mode %0d source %0d done", m, s);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    reset = 0;
    for (int m = 0; m < 3; m++) for (int s = 0; s < 3; s++) run(2'(m), 2'(s));
    summarize();
  end
  initial begin
    #(8 * 20000);
    n_errors++;
    summarize();
  end
endmodule // tb
